// [common/rwc_pkg.sv]
// shared constants for the rheostat wiper command interpreter
`default_nettype none
package rwc_pkg;
  localparam int RWC_CMD_W = 4;
  localparam int RWC_DATA_W = 10;
  localparam int RWC_FRAME_W = 16;
  localparam int RWC_SLOTS = 50;
  localparam int RWC_SLOT_AW = 6;
  localparam logic [3:0] RWC_CMD_NOP = 4'h0;
  localparam logic [3:0] RWC_CMD_WR_WIPER = 4'h1;
  localparam logic [3:0] RWC_CMD_RD_WIPER = 4'h2;
  localparam logic [3:0] RWC_CMD_STORE = 4'h3;
  localparam logic [3:0] RWC_CMD_SW_RESET = 4'h4;
  localparam logic [3:0] RWC_CMD_RD_SLOT = 4'h5;
  localparam logic [3:0] RWC_CMD_RD_LAST = 4'h6;
  localparam logic [3:0] RWC_CMD_WR_CTRL = 4'h7;
  localparam logic [3:0] RWC_CMD_RD_CTRL = 4'h8;
  localparam logic [3:0] RWC_CMD_SHUTDOWN = 4'h9;
  localparam int RWC_CTRL_PEN = 0;
  localparam int RWC_CTRL_UNLOCK = 1;
  localparam int RWC_CTRL_CALDIS = 2;
  localparam int RWC_CTRL_FUSEOK = 3;
  localparam logic [3:0] RWC_CTRL_RST = 4'h0;
  localparam logic [9:0] RWC_MID_WIDE = 10'h200;
  localparam logic [9:0] RWC_MID_NARROW = 10'h080;
  localparam logic [6:0] RWC_I2C_ADDR = 7'h2c;
  localparam int RWC_PROG_CYCLES = 64;
  localparam logic [7:0] RWC_ADDR_RST = 8'h00;
endpackage : rwc_pkg
`default_nettype wire

// [design/rwc_core.sv]
// i2c command interpreter with control flags and one-time wiper store
`default_nettype none
// How it works
// - store_program_enable resets 0; store programming only when it is 1
// - wiper_write_unlock resets 0; wiper writes only take effect when 1
// - while locked, wiper holds its current value: last stored value, midscale, or the last write made while unlocked
// - tolerance_calibration_disable resets 0; writing 1 turns calibration off
// - fuse_program_success read-only, 0 at reset, 1 after a store succeeds
// - slot addresses 0x01..0x32 map to stored values in order; 0 reserved
// - slot selection ignores top data bits
// - each enabled store write into a free slot starts a busy cycle with no acknowledge
// - address acknowledged only after the busy cycle ends
// - reset from command 4 or the low reset pin
// - reset loads wiper from most recently programmed slot
// - reset loads midscale when no slot programmed
// - command 9 with d0 set enters shutdown
// - all commands still execute during shutdown
// - command 9 with d0 clear, or any reset, leaves shutdown
// - wiper code is 10 bits wide or 8 bits narrow
// - power-up presets midscale then restores last stored value
// - frame is 4-bit command above 10-bit data; command 7 writes control
// - slot read takes six low bits, returns contents next frame
// - command 6 returns address of last programmed slot
// - command 3 stores wiper into next free slot when enabled
module rwc_core
  import rwc_pkg::*;
#(
  parameter bit WIDE = 1'b1,
  parameter int PROG_CYCLES = RWC_PROG_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic reset_pin_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic [9:0] wiper_code,
  output logic shutdown,
  output logic cal_disable,
  output logic busy
);
  initial begin
    if (PROG_CYCLES < 1 || PROG_CYCLES > 65535) $error("bad PROG_CYCLES");
  end

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK,
    ST_RX,
    ST_TX,
    ST_TXACK,
    ST_SKIP
  } rwc_state_t;

  typedef struct packed {
    logic scl_d;
    logic sda_d;
    rwc_state_t st;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic rw;
    logic byte_hi;
    logic [7:0] hi_byte;
    logic [15:0] tx_word;
    logic [15:0] nxt_tx;
    logic [3:0] ctrl;
    logic [9:0] wiper;
    logic sdn;
    logic [5:0] used;
    logic [15:0] busy_cnt;
    logic busy_f;
    logic boot;
    logic sda_o;
    logic sda_oen;
  } rwc_core_st_t;

  rwc_core_st_t st_ff;
  rwc_core_st_t nxt_st;
  logic [9:0] slot_mem_ff [RWC_SLOTS];
  // programmed slot count, kept across resets like the fuse array
  logic [5:0] used_nv_ff = 6'h00;
  logic slot_we;
  logic scl_s;
  logic sda_s;
  logic rstpin_s;
  logic [9:0] mid_code;
  logic [9:0] last_val;
  logic [15:0] frame;
  logic [5:0] sel;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;

  rwc_sync #(.RST_VAL(1'b1)) u_scl (
    .clk_sys(clk_sys), .reset_n(reset_n), .d_in(scl_in), .q_out(scl_s));
  rwc_sync #(.RST_VAL(1'b1)) u_sda (
    .clk_sys(clk_sys), .reset_n(reset_n), .d_in(sda_in), .q_out(sda_s));
  rwc_sync #(.RST_VAL(1'b1)) u_rst (
    .clk_sys(clk_sys), .reset_n(reset_n), .d_in(reset_pin_n), .q_out(rstpin_s));

  assign mid_code = WIDE ? RWC_MID_WIDE : RWC_MID_NARROW;
  assign last_val = (st_ff.used == 6'h00) ? mid_code : slot_mem_ff[st_ff.used - 6'h01];
  assign frame = {st_ff.hi_byte, st_ff.shreg[6:0], sda_s};
  assign sel = frame[5:0];
  assign scl_rise = scl_s && !st_ff.scl_d;
  assign scl_fall = !scl_s && st_ff.scl_d;
  assign start_c = scl_s && st_ff.sda_d && !sda_s;
  assign stop_c = scl_s && !st_ff.sda_d && sda_s;

  always_comb begin
    nxt_st = st_ff;
    slot_we = 1'b0;
    nxt_st.scl_d = scl_s;
    nxt_st.sda_d = sda_s;
    if (st_ff.busy_cnt != 16'h0000) begin
      nxt_st.busy_cnt = st_ff.busy_cnt - 16'h0001;
    end
    if (st_ff.boot) begin
      nxt_st.boot = 1'b0;
      nxt_st.wiper = last_val;
    end
    if (!rstpin_s) begin
      nxt_st.wiper = last_val;
      nxt_st.sdn = 1'b0;
      nxt_st.ctrl = RWC_CTRL_RST;
    end
    if (stop_c || start_c) begin
      nxt_st.st = start_c ? ST_ADDR : ST_IDLE;
      nxt_st.bitcnt = 4'h0;
      nxt_st.byte_hi = 1'b1;
      nxt_st.sda_oen = 1'b1;
      nxt_st.sda_o = 1'b1;
    end else begin
      unique case (st_ff.st)
        ST_IDLE: begin
          nxt_st.sda_oen = 1'b1;
        end
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            nxt_st.shreg = {st_ff.shreg[6:0], sda_s};
            nxt_st.bitcnt = st_ff.bitcnt + 4'h1;
            if (st_ff.bitcnt == 4'h7) begin
              if (st_ff.st == ST_ADDR) begin
                nxt_st.rw = sda_s;
                // read phase returns word prepared by last frame
                nxt_st.tx_word = st_ff.nxt_tx;
                if (st_ff.shreg[6:0] == RWC_I2C_ADDR && st_ff.busy_cnt == 16'h0000) begin
                  nxt_st.st = ST_ACK;
                end else begin
                  nxt_st.st = ST_SKIP;
                end
              end else begin
                nxt_st.st = ST_ACK;
                if (st_ff.byte_hi) begin
                  nxt_st.hi_byte = {st_ff.shreg[6:0], sda_s};
                end else begin
                  nxt_st.tx_word = st_ff.nxt_tx;
                  unique case (frame[13:10])
                    RWC_CMD_WR_WIPER: begin
                      if (st_ff.ctrl[RWC_CTRL_UNLOCK]) begin
                        nxt_st.wiper = WIDE ? frame[9:0] : {2'b00, frame[9:2]};
                      end
                    end
                    RWC_CMD_RD_WIPER: nxt_st.nxt_tx = {6'h00, st_ff.wiper};
                    RWC_CMD_STORE: begin
                      if (st_ff.ctrl[RWC_CTRL_PEN] && st_ff.used < 6'(RWC_SLOTS)) begin
                        slot_we = 1'b1;
                        nxt_st.used = st_ff.used + 6'h01;
                        nxt_st.ctrl[RWC_CTRL_FUSEOK] = 1'b1;
                        nxt_st.busy_cnt = 16'(PROG_CYCLES);
                      end
                    end
                    RWC_CMD_SW_RESET: begin
                      nxt_st.wiper = last_val;
                      nxt_st.sdn = 1'b0;
                    end
                    RWC_CMD_RD_SLOT: begin
                      if (sel != 6'h00 && sel <= st_ff.used) begin
                        nxt_st.nxt_tx = {6'h00, slot_mem_ff[sel - 6'h01]};
                      end else begin
                        nxt_st.nxt_tx = 16'h0000;
                      end
                    end
                    RWC_CMD_RD_LAST: nxt_st.nxt_tx = {10'h000, st_ff.used};
                    RWC_CMD_WR_CTRL: begin
                      nxt_st.ctrl[2:0] = frame[2:0];
                    end
                    RWC_CMD_RD_CTRL: nxt_st.nxt_tx = {12'h000, st_ff.ctrl};
                    RWC_CMD_SHUTDOWN: nxt_st.sdn = frame[0];
                    default: nxt_st.nxt_tx = st_ff.nxt_tx;
                  endcase
                end
                nxt_st.byte_hi = !st_ff.byte_hi;
              end
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (st_ff.sda_oen) begin
              nxt_st.sda_o = 1'b0;
              nxt_st.sda_oen = 1'b0;
            end else begin
              nxt_st.sda_o = 1'b1;
              nxt_st.sda_oen = 1'b1;
              nxt_st.bitcnt = 4'h0;
              nxt_st.st = st_ff.rw ? ST_TX : ST_RX;
              if (st_ff.rw) begin
                nxt_st.sda_o = st_ff.tx_word[15];
                nxt_st.sda_oen = 1'b0;
                nxt_st.tx_word = {st_ff.tx_word[14:0], 1'b0};
              end
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            nxt_st.bitcnt = st_ff.bitcnt + 4'h1;
            if (st_ff.bitcnt == 4'h7) begin
              nxt_st.sda_oen = 1'b1;
              nxt_st.sda_o = 1'b1;
              nxt_st.st = ST_TXACK;
            end else begin
              nxt_st.sda_o = st_ff.tx_word[15];
              nxt_st.sda_oen = 1'b0;
              nxt_st.tx_word = {st_ff.tx_word[14:0], 1'b0};
            end
          end
        end
        ST_TXACK: begin
          // drive only from the next scl fall, never while scl is high
          if (scl_rise) begin
            nxt_st.st = sda_s ? ST_SKIP : ST_TX;
            nxt_st.bitcnt = 4'hf;
          end
        end
        ST_SKIP: begin
          nxt_st.sda_oen = 1'b1;
          nxt_st.sda_o = 1'b1;
        end
        default: nxt_st.st = ST_IDLE;
      endcase
    end
    nxt_st.busy_f = (nxt_st.busy_cnt != 16'h0000);
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      st_ff <= '0;
      st_ff.scl_d <= 1'b1;
      st_ff.sda_d <= 1'b1;
      st_ff.st <= ST_IDLE;
      st_ff.byte_hi <= 1'b1;
      st_ff.ctrl <= RWC_CTRL_RST;
      st_ff.wiper <= WIDE ? RWC_MID_WIDE : RWC_MID_NARROW;
      st_ff.boot <= 1'b1;
      st_ff.used <= used_nv_ff;
      st_ff.sda_o <= 1'b1;
      st_ff.sda_oen <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // store survives reset: it is the nonvolatile array
  always_ff @(posedge clk_sys) begin
    if (slot_we) begin
      slot_mem_ff[st_ff.used] <= st_ff.wiper;
      used_nv_ff <= st_ff.used + 6'h01;
    end
  end

  assign sda_out = st_ff.sda_o;
  assign sda_oe_n = st_ff.sda_oen;
  assign wiper_code = st_ff.wiper;
  assign shutdown = st_ff.sdn;
  assign cal_disable = st_ff.ctrl[RWC_CTRL_CALDIS];
  assign busy = st_ff.busy_f;
endmodule : rwc_core
`default_nettype wire

// [design/rwc_sync.sv]
// two-stage synchroniser for pin inputs
`default_nettype none
module rwc_sync
  import rwc_pkg::*;
#(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic d_in,
  output logic q_out
);
  typedef struct packed {
    logic s1;
    logic s2;
  } rwc_sync_st_t;
  rwc_sync_st_t st_ff;
  rwc_sync_st_t nxt_st;
  always_comb begin
    nxt_st.s1 = d_in;
    nxt_st.s2 = st_ff.s1;
  end
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      st_ff <= '{s1: RST_VAL, s2: RST_VAL};
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign q_out = st_ff.s2;
endmodule : rwc_sync
`default_nettype wire

// [verification/rwc_core_bench.sv]
// self-checking bench for the rheostat command interpreter
`default_nettype none
module rwc_core_bench import rwc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic reset_pin_n = 1'b1;
  logic scl, h_sda, sda_out, sda_oe_n, shutdown, cal_disable, busy, ack;
  logic [9:0] wiper_code, v;
  logic [15:0] w;
  logic [9:0] st [1:50];
  logic [5:0] sl [4] = '{6'h00, 6'h01, 6'h19, 6'h32};
  int used = 0;
  int miscompares = 0;
  int n_compared = 0;
  wire logic sda_line;
  assign sda_line = h_sda & (sda_oe_n | sda_out);
  initial forever #20 clk_sys = ~clk_sys;
  rwc_host u_h (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda_o(h_sda));
  rwc_core #(.WIDE(1'b1), .PROG_CYCLES(200)) dut_u (.clk_sys(clk_sys), .reset_n(reset_n),
    .reset_pin_n(reset_pin_n), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .wiper_code(wiper_code), .shutdown(shutdown),
    .cal_disable(cal_disable), .busy(busy));
  function automatic logic [9:0] last_val();
    return used == 0 ? RWC_MID_WIDE : st[used];
  endfunction : last_val
  task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  task automatic test_done;
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  task automatic wr(input logic [3:0] c, input logic [9:0] d);
    u_h.xfer(1'b0, {2'b00, c, d}, 2, w, ack);
    chk(10'(ack), 10'h001, "frame not acked");
    repeat (4) @(negedge clk_sys);
  endtask : wr
  task automatic rd(input logic [3:0] c, input logic [9:0] d, input logic [9:0] e);
    wr(c, d);
    u_h.xfer(1'b1, 16'h0000, 2, w, ack);
    chk(w[9:0], e, "read word");
  endtask : rd
  task automatic store(input bit fresh);
    u_h.xfer(1'b0, {2'b00, RWC_CMD_STORE, 10'h3ff}, 2, w, ack);
    u_h.xfer(1'b0, w, 0, w, ack);
    if (fresh) chk(10'(ack), 10'h000, "acked while busy");
    for (int i = 0; i < 10 && !ack; i++) u_h.xfer(1'b0, w, 0, w, ack);
    chk(10'(ack), 10'h001, "no ack after store");
  endtask : store
  initial begin
    #4_000_000;
    miscompares++;
    $display("[FAIL] %0t watchdog", $time);
    test_done();
  end
  initial begin
    void'($urandom(32'hbfebc434));
    repeat (8) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk(wiper_code, last_val(), "preset");
    v = 10'($urandom);
    wr(RWC_CMD_WR_WIPER, v);
    chk(wiper_code, last_val(), "locked write moved wiper");
    wr(RWC_CMD_WR_CTRL, 10'h3fe);
    chk(10'(cal_disable), 10'h001, "calibration on");
    store(1'b0);
    rd(RWC_CMD_RD_CTRL, 10'h000, 10'h006);
    $display("test lock done");
    wr(RWC_CMD_WR_CTRL, 10'h003);
    for (int i = 1; i <= 51; i++) begin
      v = 10'($urandom);
      wr(RWC_CMD_WR_WIPER, v);
      chk(wiper_code, v, "wiper write lost");
      store(i <= 50);
      if (i <= 50) st[i] = v;
      used = (i > 50) ? 50 : i;
      if (i == 1) rd(RWC_CMD_RD_CTRL, 10'h000, 10'h00b);
    end
    rd(RWC_CMD_RD_LAST, 10'h000, 10'h032);
    rd(RWC_CMD_RD_WIPER, 10'h000, v);
    foreach (sl[k]) rd(RWC_CMD_RD_SLOT, {4'he, sl[k]}, k == 0 ? 10'h000 : st[sl[k]]);
    $display("test store done");
    wr(RWC_CMD_SHUTDOWN, 10'h001);
    chk(10'(shutdown), 10'h001, "no shutdown");
    v = 10'($urandom);
    wr(RWC_CMD_WR_WIPER, v);
    chk(wiper_code, v, "write lost in shutdown");
    wr(RWC_CMD_SHUTDOWN, 10'h3fe);
    chk(10'(shutdown), 10'h000, "shutdown stuck");
    wr(RWC_CMD_SHUTDOWN, 10'h001);
    wr(RWC_CMD_SW_RESET, 10'h000);
    chk(10'(shutdown), 10'h000, "reset kept shutdown");
    chk(wiper_code, last_val(), "soft reset restore");
    wr(RWC_CMD_SHUTDOWN, 10'h001);
    reset_pin_n = 1'b0;
    repeat (6) @(negedge clk_sys);
    reset_pin_n = 1'b1;
    repeat (6) @(negedge clk_sys);
    chk(10'(shutdown), 10'h000, "pin reset kept shutdown");
    wr(RWC_CMD_WR_WIPER, ~v);
    chk(wiper_code, last_val(), "locked wiper moved");
    reset_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk(wiper_code, last_val(), "restore after reset");
    $display("test reset done");
    test_done();
  end
endmodule : rwc_core_bench
`default_nettype wire

// [verification/rwc_core_properties.sv]
// assertions on the rheostat command interpreter ports
`default_nettype none
module rwc_core_properties
  import rwc_pkg::*;
#(
  parameter bit WIDE = 1'b1,
  parameter int PROG_CYCLES = RWC_PROG_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic reset_pin_n,
  input wire logic scl_in,
  input wire logic sda_oe_n,
  input wire logic [9:0] wiper_code,
  input wire logic shutdown,
  input wire logic cal_disable,
  input wire logic busy
);
  localparam logic [9:0] MID = WIDE ? RWC_MID_WIDE : RWC_MID_NARROW;
  int busy_run_ff;
  default clocking cb @(posedge clk_sys);
  endclocking
  always_ff @(posedge clk_sys) busy_run_ff <= (reset_n && busy) ? busy_run_ff + 1 : 0;
  property p_rst_mid; !reset_n |=> wiper_code == MID; endproperty
  a_rst_mid: assert property (p_rst_mid) else $error("wiper off midscale");
  property p_rst_ctl; !reset_n |=> !shutdown && !cal_disable && sda_oe_n; endproperty
  a_rst_ctl: assert property (p_rst_ctl) else $error("flags kept in reset");
  property p_busy_min; disable iff (!reset_n) $rose(busy) |-> busy [*8]; endproperty
  a_busy_min: assert property (p_busy_min) else $error("busy too short");
  property p_busy_max; disable iff (!reset_n) busy_run_ff <= PROG_CYCLES + 1; endproperty
  a_busy_max: assert property (p_busy_max) else $error("busy too long");
  property p_pin; disable iff (!reset_n) (!reset_pin_n) [*4] |=> !shutdown && !cal_disable;
  endproperty
  a_pin: assert property (p_pin) else $error("pin reset ignored");
  property p_cmd; disable iff (!reset_n) $rose(shutdown) || $rose(cal_disable) || $rose(busy)
    |-> scl_in; endproperty
  a_cmd: assert property (p_cmd) else $error("command off clock high");
  property p_oe_scl; disable iff (!reset_n) $changed(sda_oe_n) |-> !scl_in; endproperty
  a_oe_scl: assert property (p_oe_scl) else $error("data moved with clock high");
  property p_oe_hold; disable iff (!reset_n) $fell(sda_oe_n) |-> !sda_oe_n [*8]; endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("drive too short");
  c_store: cover property (disable iff (!reset_n) $rose(busy));
  c_sdn: cover property (disable iff (!reset_n) $rose(shutdown));
  c_pin: cover property ((!reset_pin_n) [*4]);
endmodule : rwc_core_properties
bind rwc_core rwc_core_properties #(.WIDE(WIDE), .PROG_CYCLES(PROG_CYCLES)) u_props (
  .clk_sys(clk_sys), .reset_n(reset_n), .reset_pin_n(reset_pin_n), .scl_in(scl_in),
  .sda_oe_n(sda_oe_n), .wiper_code(wiper_code), .shutdown(shutdown),
  .cal_disable(cal_disable), .busy(busy));
`default_nettype wire

// [verification/rwc_host.sv]
// i2c host model for the rheostat command port
`default_nettype none
module rwc_host
  import rwc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sda_line,
  output logic scl,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {scl, sda_o} = 2'b11;
  task automatic hp;
    repeat (6) @(negedge clk_sys);
  endtask : hp
  task automatic bit_io(input logic b, output logic r);
    @(negedge clk_sys);
    sda_o = b;
    hp();
    scl = 1'b1;
    hp();
    r = sda_line;
    scl = 1'b0;
  endtask : bit_io
  task automatic byte_io(input logic [7:0] d, input logic last, output logic [7:0] q,
    output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(last, r);
    ack = !r;
  endtask : byte_io
  // framed hi and lo byte; nb 0 is an address probe
  task automatic xfer(input logic rd, input logic [15:0] w, input int nb,
    output logic [15:0] q, output logic ack);
    logic [7:0] j;
    logic a;
    hp();
    sda_o = 1'b0;
    hp();
    scl = 1'b0;
    byte_io({RWC_I2C_ADDR, rd}, 1'b1, j, ack);
    for (int i = 0; i < nb; i++) begin
      byte_io(rd ? 8'hff : w[15-8*i -: 8], !rd || i == nb - 1, q[15-8*i -: 8], a);
      ack = ack && (rd || a);
    end
    @(negedge clk_sys);
    sda_o = 1'b0;
    hp();
    scl = 1'b1;
    hp();
    sda_o = 1'b1;
    hp();
  endtask : xfer
endmodule : rwc_host
`default_nettype wire
